// *** logic/spm_pkg.sv ***
package spm_pkg;

  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_DATA    = 4'h8;
  localparam logic [3:0] ADDR_PINDIR  = 4'hc;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CTL_IRQ_EN    = 7;
  localparam int CTL_PORT_EN   = 6;
  localparam int CTL_LSB_FIRST = 5;
  localparam int CTL_MASTER    = 4;
  localparam int CTL_CLOCK_IDLE_LEVEL      = 3;
  localparam int CTL_CLOCK_SAMPLE_PHASE      = 2;
  localparam int STS_DONE      = 7;
  localparam int STS_COLL      = 6;
  localparam int STS_DOUBLE    = 0;
  localparam int DIR_MOSI      = 0;
  localparam int DIR_MISO      = 1;
  localparam int DIR_SCK       = 2;
  localparam int DIR_SS        = 3;
  localparam int DIR_SS_LEVEL  = 4;

  // ****************************************************
  // Counts
  // ****************************************************
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [2:0] LAST_BIT  = 3'h7;
  // Half period in clocks, index {double_speed, rate_divider_sel}
  localparam logic [6:0] HALF_TABLE [8] = '{
    7'h02, 7'h08, 7'h20, 7'h40, 7'h01, 7'h04, 7'h10, 7'h20
  };

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    logic [7:0] control;
    logic       doubleSpeed;
    logic [4:0] pinDir;
    logic [7:0] shift;
    logic       outBit;
    logic [7:0] rxBuf;
    logic       xferDone;
    logic       writeColl;
    logic       armed;
    logic       running;
    logic [6:0] divCnt;
    logic [3:0] edgeCnt;
    logic       sckLvl;
    logic [2:0] bitCnt;
    logic       sckPrev;
    logic       waitReq;
    logic [7:0] readData;
    logic       irq;
    logic       mosiOut;
    logic       mosiOe;
    logic       misoOut;
    logic       misoOe;
    logic       sckOut;
    logic       sckOe;
    logic       ssOut;
    logic       ssOe;
  } spm_state_t;

  localparam spm_state_t STATE_RST = '{waitReq: 1'b1, default: '0};

endpackage

// *** logic/spm_spi_port.sv ***
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Functional notes
// [R01] Slave: select is input; low activates, MISO driven only if enabled.
// [R02] Slave: select high keeps port passive, pins inputs, data ignored.
// [R03] Slave: select high at once clears bit counter and partial byte; the code clears only bitCnt and the shift register keeps its bits.
// [R04] Master with select as output: plain output, no SPI effect.
// [R05] Master with select input low: clear master bit, become slave.
// [R06] That forced fall back also sets the completion flag.
// [R07] Software must set master bit again; handler checks it.
// [R08] Clock polarity bit gives the idle level of the serial clock.
// [R09] Phase zero samples on leading edge; phase one on trailing.
// [R10] Interrupt requested when flag, enable and global enable all set.
// [R11] Port enable zero stops every SPI operation.
// [R12] Bit order bit one sends LSB first, zero MSB first.
// [R13] Role bit one selects master, zero slave.
// [R14] Master clock divides by 4,16,64,128 or 2,8,32,64 doubled.
// [R15] Completion flag set at end; cleared by vector or read sequence.
// [R16] Collision flag set by data write during a transfer.
// [R17] Status bits 5 to 1 always read zero.
// [R18] Double speed bit halves master clock period, minimum two clocks.
// [R19] Remote master keeps its clock at most a quarter of ours.
// [R20] Data write starts transfer; data read returns receive buffer.
// [R21] Master stops clock after eight bits and sets completion flag.
// [R22] Receive double buffered; byte must be read before next one ends.
// [R23] Status read with flags set is remembered; data access then clears.
module spm_spi_port
  import spm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic      [31:0] avsReadData,
  output logic             avsWaitRequest,
  input  wire logic        globalIrqEnable,
  input  wire logic        irqAck,
  output logic             irq,
  input  wire logic        sckIn,
  output logic             sckOut,
  output logic             sckOe,
  input  wire logic        mosiIn,
  output logic             mosiOut,
  output logic             mosiOe,
  input  wire logic        misoIn,
  output logic             misoOut,
  output logic             misoOe,
  input  wire logic        ssIn,
  output logic             ssOut,
  output logic             ssOe
);
  import spm_pkg::*;

  // ****************************************************
  // Reset release
  // ****************************************************
  logic [1:0] rstPipe;
  logic       rstSyncN;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSyncN = rstPipe[1];

  // ****************************************************
  // Next state
  // ****************************************************
  spm_state_t s;
  spm_state_t n;
  logic       en;
  logic       mst;
  logic       lsb;
  logic       clock_idle_level;
  logic       clock_sample_phase;
  logic       acc;
  logic       wrOk;
  logic       rdAcc;
  logic       dataAcc;
  logic       busy;
  logic       startXfer;
  logic       forced;
  logic       doneSet;
  logic       wcolSet;
  logic       inBit;
  logic       tick;
  logic       sckEdge;
  logic       lead;
  logic       sampleNow;
  logic       setupNow;
  logic       nextMst;
  logic [7:0] shIn;
  logic [6:0] halfCnt;

  always_comb begin
    n = s;
    en = s.control[CTL_PORT_EN];
    mst = s.control[CTL_MASTER];
    lsb = s.control[CTL_LSB_FIRST];
    clock_idle_level = s.control[CTL_CLOCK_IDLE_LEVEL];
    clock_sample_phase = s.control[CTL_CLOCK_SAMPLE_PHASE];

    // Bus: one wait cycle, then a single acknowledge cycle
    acc = (avsRead | avsWrite) & ~s.waitReq;
    n.waitReq = ~((avsRead | avsWrite) & s.waitReq);
    wrOk = acc & avsWrite & avsByteEnable[0];
    rdAcc = acc & avsRead;
    dataAcc = acc & (avsAddress == ADDR_DATA);

    busy = s.running | (s.bitCnt != 3'h0);
    startXfer = wrOk & (avsAddress == ADDR_DATA) & en & ~busy; // R20
    wcolSet = wrOk & (avsAddress == ADDR_DATA) & en & busy; // R16
    forced = en & mst & ~s.pinDir[DIR_SS] & ~ssIn; // R05
    doneSet = forced; // R06

    // Master clock generator
    halfCnt = HALF_TABLE[{s.doubleSpeed, s.control[1:0]}]; // R14 R18
    tick = s.running & (s.divCnt == halfCnt - 7'h01);
    if (s.running) begin
      n.divCnt = tick ? 7'h00 : s.divCnt + 7'h01;
    end
    if (tick) begin
      n.sckLvl = ~s.sckLvl;
      n.edgeCnt = s.edgeCnt + 4'h1;
    end else if (!s.running) begin
      n.sckLvl = clock_idle_level; // R08
    end

    // Slave edge detection, only while selected
    n.sckPrev = sckIn;
    sckEdge = en & ~mst & ~ssIn & (sckIn != s.sckPrev); // R01 R02
    lead = mst ? ~s.edgeCnt[0] : (sckIn != clock_idle_level); // R08
    sampleNow = (tick | sckEdge) & (lead ^ clock_sample_phase); // R09
    setupNow = (tick | sckEdge) & ~(lead ^ clock_sample_phase); // R09
    inBit = mst ? misoIn : mosiIn; // R13

    // Shifter
    shIn = lsb ? {inBit, s.shift[7:1]} : {s.shift[6:0], inBit}; // R12
    if (sampleNow) begin
      n.shift = shIn;
      if (!mst) begin
        n.bitCnt = s.bitCnt + 3'h1;
      end
    end
    if (setupNow) begin
      n.outBit = lsb ? s.shift[0] : s.shift[7]; // R12
    end
    if (sampleNow && !mst && s.bitCnt == LAST_BIT) begin
      n.rxBuf = shIn; // R22
      doneSet = 1'b1; // R15
    end
    if (tick && s.edgeCnt == LAST_EDGE) begin
      n.running = 1'b0; // R21
      n.rxBuf = sampleNow ? shIn : s.shift; // R22
      doneSet = 1'b1; // R21
    end
    if (!mst && ssIn) begin
      n.bitCnt = 3'h0; // R03
    end

    // Transfer start
    if (startXfer) begin
      n.shift = avsWriteData[7:0];
      n.outBit = lsb ? avsWriteData[0] : avsWriteData[7]; // R12
      if (mst) begin
        n.running = 1'b1; // R13
        n.divCnt = 7'h00;
        n.edgeCnt = 4'h0;
        n.sckLvl = clock_idle_level;
      end
    end

    // Register writes
    if (wrOk) begin
      unique case (avsAddress)
        ADDR_CONTROL: n.control = avsWriteData[7:0];
        ADDR_STATUS:  n.doubleSpeed = avsWriteData[STS_DOUBLE]; // R18
        ADDR_PINDIR:  n.pinDir = avsWriteData[4:0];
        default:      n.pinDir = s.pinDir;
      endcase
    end

    // Disabled port and forced fall back to slave
    if (!n.control[CTL_PORT_EN]) begin
      n.running = 1'b0; // R11
      n.bitCnt = 3'h0; // R11
    end
    if (forced) begin
      n.control[CTL_MASTER] = 1'b0; // R05
      n.running = 1'b0;
      n.edgeCnt = 4'h0;
      n.sckLvl = clock_idle_level;
    end

    // Flags: clears first, sets win
    if (rdAcc && avsAddress == ADDR_STATUS &&
        (s.readData[STS_DONE] | s.readData[STS_COLL])) begin
      n.armed = 1'b1; // R23
    end
    if (dataAcc && s.armed) begin
      n.xferDone = 1'b0; // R15 R23
      n.writeColl = 1'b0; // R16 R23
      n.armed = 1'b0;
    end
    if (irqAck) begin
      n.xferDone = 1'b0; // R15
    end
    if (doneSet) begin
      n.xferDone = 1'b1; // R15
    end
    if (wcolSet) begin
      n.writeColl = 1'b1; // R16
    end

    // Read data, loaded while the request waits
    if (avsRead && s.waitReq) begin
      unique case (avsAddress)
        ADDR_CONTROL: n.readData = s.control;
        ADDR_STATUS:  n.readData = {s.xferDone, s.writeColl, 5'h00,
                                    s.doubleSpeed}; // R17
        ADDR_DATA:    n.readData = s.rxBuf; // R20
        ADDR_PINDIR:  n.readData = {3'h0, s.pinDir};
        default:      n.readData = 8'h00;
      endcase
    end

    n.irq = n.xferDone & n.control[CTL_IRQ_EN] & globalIrqEnable; // R10

    // Pin drivers
    nextMst = n.control[CTL_PORT_EN] & n.control[CTL_MASTER];
    n.sckOut = n.sckLvl;
    n.mosiOut = n.outBit;
    n.misoOut = n.outBit;
    n.ssOut = n.pinDir[DIR_SS_LEVEL]; // R04
    n.sckOe = nextMst & n.pinDir[DIR_SCK]; // R05
    n.mosiOe = nextMst & n.pinDir[DIR_MOSI]; // R05
    n.ssOe = nextMst & n.pinDir[DIR_SS]; // R04
    n.misoOe = n.control[CTL_PORT_EN] & ~n.control[CTL_MASTER] &
               n.pinDir[DIR_MISO] & ~ssIn; // R01 R02
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign avsReadData = {24'h000000, s.readData};
  assign avsWaitRequest = s.waitReq;
  assign irq = s.irq;
  assign sckOut = s.sckOut;
  assign sckOe = s.sckOe;
  assign mosiOut = s.mosiOut;
  assign mosiOe = s.mosiOe;
  assign misoOut = s.misoOut;
  assign misoOe = s.misoOe;
  assign ssOut = s.ssOut;
  assign ssOe = s.ssOe;

endmodule

// *** verification/spm_remote.sv ***
`timescale 1ns/1ps
module spm_remote (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ssN,
  input  wire logic       clock_sample_phase,
  input  wire logic       clock_idle_level,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  logic [7:0] tx;
  int         cnt;
  // Released line shows the inverse so a stale bit never passes
  assign miso = ssN ? ~tx[7] : tx[7];
  always @(negedge ssN) begin
    tx = txByte;
    cnt = 0;
  end
  always @(sck) begin
    if (!ssN && ((sck != clock_idle_level) ^ clock_sample_phase)) begin
      rxByte = {rxByte[6:0], mosi};
      cnt++;
    end else if (!ssN && cnt != 0) begin
      tx = {tx[6:0], 1'b0};
    end
  end
endmodule

// *** verification/spm_props.sv ***
`timescale 1ns/1ps
module spm_props
  import spm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [3:0]  avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0]  avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  input wire logic        globalIrqEnable,
  input wire logic        irqAck,
  input wire logic        irq,
  input wire logic        ssIn,
  input wire logic        sckOut,
  input wire logic        sckOe,
  input wire logic        mosiOe,
  input wire logic        misoOe,
  input wire logic        ssOut,
  input wire logic        ssOe
);
  import spm_pkg::*;
  logic [7:0] ctlR;
  logic [7:0] pdR;
  logic       dsR;
  logic       wrAck;
  assign wrAck = !avsWaitRequest && avsWrite && avsByteEnable[0];
  // Mirror of software writes to control and pin direction
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctlR <= 8'h00;
      pdR <= 8'h00;
      dsR <= 1'b0;
    end else if (wrAck && avsAddress == ADDR_STATUS) begin
      dsR <= avsWriteData[STS_DOUBLE];
    end else if (wrAck && avsAddress == ADDR_CONTROL) begin
      ctlR <= avsWriteData[7:0];
    end else if (wrAck && avsAddress == ADDR_PINDIR) begin
      pdR <= avsWriteData[7:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence masterSsOut;
    ctlR[CTL_PORT_EN] && ctlR[CTL_MASTER] && pdR[DIR_SS] && $stable(pdR);
  endsequence
  sequence portOff;
    !ctlR[CTL_PORT_EN] [*3];
  endsequence
  rd_zero_a: assert property (
    avsRead && !avsWaitRequest && avsAddress == ADDR_STATUS
    |-> avsReadData[5:1] == 5'h00) else $error("status spare bits set");
  irq_gate_a: assert property (
    irq |-> $past(globalIrqEnable) && ctlR[CTL_IRQ_EN])
    else $error("irq without enables");
  miso_sel_a: assert property (
    misoOe |-> $past(!ssIn) && !ctlR[CTL_MASTER] && pdR[DIR_MISO])
    else $error("miso driven while not selected");
  fallback_a: assert property (
    !ssOe && !ssIn && ctlR[CTL_PORT_EN] |-> ##[1:3] (!sckOe && !mosiOe))
    else $error("master kept pins after select low");
  idle_off_a: assert property (
    portOff |-> $stable(sckOut)) else $error("clock moved while off");
  sck_min_a: assert property (
    $changed(sckOut) && !dsR |=> $stable(sckOut))
    else $error("clock too fast");
  ack_clear_a: assert property (
    irqAck |-> ##2 !irq) else $error("vector did not clear flag");
  ss_plain_a: assert property (
    masterSsOut [*2] |-> ssOe && ssOut == pdR[DIR_SS_LEVEL])
    else $error("select output not plain");
  slave_quiet_a: assert property (
    (ctlR[CTL_PORT_EN] && !ctlR[CTL_MASTER]) [*2] |-> !sckOe && !mosiOe)
    else $error("slave drove clock or mosi");
endmodule
bind spm_spi_port spm_props spm_props_inst (
  .clk             (clk),
  .rstn            (rstn),
  .avsAddress      (avsAddress),
  .avsRead         (avsRead),
  .avsWrite        (avsWrite),
  .avsWriteData    (avsWriteData),
  .avsByteEnable   (avsByteEnable),
  .avsReadData     (avsReadData),
  .avsWaitRequest  (avsWaitRequest),
  .globalIrqEnable (globalIrqEnable),
  .irqAck          (irqAck),
  .irq             (irq),
  .ssIn            (ssIn),
  .sckOut          (sckOut),
  .sckOe           (sckOe),
  .mosiOe          (mosiOe),
  .misoOe          (misoOe),
  .ssOut           (ssOut),
  .ssOe            (ssOe)
);

// *** verification/test_spm_spi_port.sv ***
`timescale 1ns/1ps
module test_spm_spi_port;
  import spm_pkg::*;
  logic        clk = 0, rstn = 0, avsRead = 0, avsWrite = 0, irqAck = 0;
  logic        globalIrqEnable = 0, extSs = 1, extSck = 0, extMosi = 0;
  logic        mCpol = 0, mCpha = 0, avsWaitRequest, irq, remMiso;
  logic        sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, ssOut, ssOe;
  logic [3:0]  avsAddress = 0, avsByteEnable = 4'hf;
  logic [31:0] avsWriteData = 0, avsReadData;
  logic [7:0]  rxByte, q, txd = 0, d, rb = 0;
  logic [15:0] n, qe[$];
  integer      seed = 32'h41a1b75c;
  int          failures = 0, checks_done = 0, cyc = 0;
  wire         ssIn = ssOe ? ssOut : extSs;
  wire         sckIn = sckOe ? sckOut : extSck;
  wire         mosiIn = mosiOe ? mosiOut : extMosi;
  wire         misoIn = misoOe ? misoOut : remMiso;
  spm_spi_port spm_spi_port_inst (
    .clk             (clk),
    .rstn            (rstn),
    .avsAddress      (avsAddress),
    .avsRead         (avsRead),
    .avsWrite        (avsWrite),
    .avsWriteData    (avsWriteData),
    .avsByteEnable   (avsByteEnable),
    .avsReadData     (avsReadData),
    .avsWaitRequest  (avsWaitRequest),
    .globalIrqEnable (globalIrqEnable),
    .irqAck          (irqAck),
    .irq             (irq),
    .sckIn           (sckIn),
    .sckOut          (sckOut),
    .sckOe           (sckOe),
    .mosiIn          (mosiIn),
    .mosiOut         (mosiOut),
    .mosiOe          (mosiOe),
    .misoIn          (misoIn),
    .misoOut         (misoOut),
    .misoOe          (misoOe),
    .ssIn            (ssIn),
    .ssOut           (ssOut),
    .ssOe            (ssOe)
  );
  spm_remote spm_remote_inst (.sck(sckIn), .mosi(mosiIn), .ssN(ssIn),
    .clock_sample_phase(mCpha), .clock_idle_level(mCpol), .txByte(txd), .miso(remMiso),
    .rxByte(rxByte));
  always #5 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= {24'h0, v};
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    q = avsReadData[7:0];
    avsRead <= 0;
    avsWrite <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    qe.push_back({m, e & m});
    bus(0, a, 0);
  endtask
  // Remote master sends the top k bits of v in mode 0, records misoOut
  task sbits(input int k, input logic [7:0] v);
    extSs <= 0;
    for (int j = 7; j > 7 - k; j--) begin
      extMosi <= v[j];
      repeat (4) @(posedge clk);
      rb = {rb[6:0], misoOut};
      extSck <= 1;
      repeat (4) @(posedge clk);
      extSck <= 0;
    end
    extSs <= 1;
  endtask
  task xfer(input logic [7:0] c, input logic [7:0] s, input logic coll);
    logic [7:0] r1, r2;
    mCpol = c[CTL_CLOCK_IDLE_LEVEL];
    mCpha = c[CTL_CLOCK_SAMPLE_PHASE];
    txd = 8'($random(seed));
    d = 8'($random(seed));
    r1 = {<<{txd}};
    r2 = {<<{d}};
    bus(1, ADDR_PINDIR, 8'h1d);
    bus(1, ADDR_STATUS, s);
    bus(1, ADDR_CONTROL, c);
    bus(1, ADDR_PINDIR, 8'h0d);
    bus(1, ADDR_DATA, d);
    if (coll) bus(1, ADDR_DATA, ~d);
    do rd(ADDR_STATUS, 8'h0, 8'h0); while (q[STS_DONE] !== 1'b1);
    rd(ADDR_STATUS, {1'b1, coll, 6'h0} | s, 8'hff);
    rd(ADDR_DATA, c[CTL_LSB_FIRST] ? r1 : txd, 8'hff);
    chk(rxByte, c[CTL_LSB_FIRST] ? r2 : d);
    chk({7'h0, sckOut}, {7'h0, c[CTL_CLOCK_IDLE_LEVEL]});
    rd(ADDR_STATUS, s, 8'hff);
    $display("transfer with control %h done", c);
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (avsRead && avsWaitRequest === 1'b0) begin
      n = qe.pop_front();
      chk(avsReadData[7:0] & n[15:8], n[7:0]);
    end
  end
  always @(posedge clk) begin
    if (++cyc == 20000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    rd(ADDR_CONTROL, 8'h00, 8'hff);
    rd(ADDR_PINDIR, 8'h00, 8'hff);
    bus(1, 4'h2, 8'hff);
    rd(4'h2, 8'h00, 8'hff);
    bus(1, ADDR_STATUS, 8'hfe);
    rd(ADDR_STATUS, 8'h00, 8'hff);
    $display("register reset tests done");
    for (int i = 0; i < 8; i++) begin
      xfer({2'b01, i[2], 1'b1, i[1:0], i[1:0]}, {7'h0, i[2]}, i == 5);
    end
    // ****************************************************
    // Slave exchange with a bench-driven remote master, then fall back, irq and port off
    // ****************************************************
    bus(1, ADDR_PINDIR, 8'h02);
    bus(1, ADDR_CONTROL, 8'h40);
    d = 8'($random(seed));
    sbits(3, ~d);
    txd = 8'($random(seed));
    bus(1, ADDR_DATA, txd);
    sbits(8, d);
    chk(rb, txd);
    rd(ADDR_STATUS, 8'h80, 8'h80);
    rd(ADDR_DATA, d, 8'hff);
    bus(1, ADDR_PINDIR, 8'h05);
    bus(1, ADDR_CONTROL, 8'h50);
    extSs <= 0;
    repeat (4) @(posedge clk);
    rd(ADDR_CONTROL, 8'h40, 8'hff);
    rd(ADDR_STATUS, 8'h80, 8'h80);
    extSs <= 1;
    bus(1, ADDR_CONTROL, 8'hd0);
    rd(ADDR_CONTROL, 8'hd0, 8'hff);
    bus(1, ADDR_DATA, d);
    globalIrqEnable <= 1;
    while (irq !== 1'b1) @(posedge clk);
    rd(ADDR_DATA, 8'h00, 8'h00);
    rd(ADDR_STATUS, 8'h81, 8'hff);
    irqAck <= 1;
    @(posedge clk);
    irqAck <= 0;
    rd(ADDR_STATUS, 8'h01, 8'hff);
    bus(1, ADDR_CONTROL, 8'h00);
    bus(1, ADDR_DATA, 8'h5a);
    repeat (40) @(posedge clk);
    rd(ADDR_STATUS, 8'h01, 8'hff);
    $display("slave, fall back, irq and off tests done");
    wrap_up;
  end
endmodule
